//--- hdl/fault_decide.sv
// combinational transmit decision from configuration bits and live fault status
// assumes the status arrives already clean on aclk
`timescale 1ns/1ps
module fault_decide
    import lfs_pkg::*;
(
    input  wire logic [3:0] cfg,
    fault_status_if.dec     st
);
    always_comb begin
        st.action = TX_PASS;
        if (!cfg[CFG_ENABLE_BIT]) begin
            st.action = TX_PASS;
        end else if (cfg[CFG_FORCE_BIT]) begin
            st.action = TX_RF;
        end else if (cfg[CFG_UNIDIR_BIT]) begin
            if (cfg[CFG_COMPAT_BIT])
                st.action = TX_PASS;
            else if (st.local_fault_condition)
                st.action = TX_DATA_RF;
            else
                st.action = TX_PASS;
        end else begin
            if (st.local_fault_condition)
                st.action = TX_RF;
            else if (st.remote_fault_condition)
                st.action = TX_IDLE;
            else
                st.action = TX_PASS;
        end
    end
endmodule : fault_decide

//--- hdl/fault_status_if.sv
// interface carrying the receive fault status and the transmit decision
// assumes one clock shared by all users
`timescale 1ns/1ps
interface fault_status_if;
    import lfs_pkg::*;
    logic       local_fault_condition;
    logic       remote_fault_condition;
    tx_action_e action;
    modport rx  (output local_fault_condition, output remote_fault_condition);
    modport dec (input local_fault_condition, input remote_fault_condition, output action);
    modport tx  (input action);
endinterface : fault_status_if

//--- hdl/lfs_pkg.sv
// package for the link fault signaling block: register map, field positions, reset values
// assumes a 32-bit AXI4-Lite register bus with byte addresses
package lfs_pkg;
    // 0x405 is not word aligned: kept as an index, byte address is four times it
    localparam logic [11:0] LINK_FAULT_CONFIG_IDX = 12'h405;
    localparam logic [11:0] INT_STATUS_IDX        = 12'h406;
    localparam logic [11:0] INT_MASK_IDX          = 12'h407;
    localparam logic [11:0] LINK_STATUS_IDX       = 12'h408;
    localparam logic [13:0] LINK_FAULT_CONFIG_ADDR = {LINK_FAULT_CONFIG_IDX, 2'b00};
    localparam logic [13:0] INT_STATUS_ADDR        = {INT_STATUS_IDX, 2'b00};
    localparam logic [13:0] INT_MASK_ADDR          = {INT_MASK_IDX, 2'b00};
    localparam logic [13:0] LINK_STATUS_ADDR       = {LINK_STATUS_IDX, 2'b00};

    localparam int CFG_ENABLE_BIT = 0;
    localparam int CFG_UNIDIR_BIT = 1;
    localparam int CFG_COMPAT_BIT = 2;
    localparam int CFG_FORCE_BIT  = 3;
    localparam logic [3:0] LINK_FAULT_CONFIG_RST = 4'h0;
    localparam logic [3:0] INT_MASK_RST          = 4'h0;

    // status event bits
    localparam int EV_LF_SET = 0;
    localparam int EV_LF_CLR = 1;
    localparam int EV_RF_SET = 2;
    localparam int EV_RF_CLR = 3;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // xgmii control characters and ordered set words
    localparam logic [7:0] CH_IDLE   = 8'h07;
    localparam logic [7:0] CH_SEQ    = 8'h9c;
    localparam logic [7:0] CH_TERM   = 8'hfd;
    localparam logic [7:0] SEQ_LOCAL  = 8'h01;
    localparam logic [7:0] SEQ_REMOTE = 8'h02;

    typedef enum logic [1:0] { TX_PASS, TX_IDLE, TX_RF, TX_DATA_RF } tx_action_e;
endpackage : lfs_pkg

//--- hdl/link_fault_signaling.sv
// top of the link fault signaling block: register slave, fault decision, transmit column mux
// assumes AXI4-Lite master on aclk, client tx columns ready on every cycle
//
// Summary of operation
// - fault status outputs follow the live link, independent of configuration.
// - bit 0 clear: send data and idles, never remote fault.
// - bits 0 and 3 set: stop data, send remote fault only.
// - unidirectional with bit 2 clear, local fault: keep data, idle column after end, send remote fault.
// - unidirectional, remote or no fault: data and idles, no remote fault.
// - bidirectional, remote fault: stop data, idles only.
// - bidirectional, no fault: normal data and idles.
// - nonzero ordered set type codes are not flagged as errors.
// - bidirectional, local fault: stop data, send remote fault continuously.
// - no fault detection while unaligned or under high error rate.
`timescale 1ns/1ps
module link_fault_signaling
    import lfs_pkg::*;
#(
    parameter int HOLD_COLUMNS = 128
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rx_valid,
    input  wire logic [63:0] rx_data,
    input  wire logic [7:0]  rx_ctrl,
    input  wire logic        rx_aligned,
    input  wire logic        rx_hi_ber,
    input  wire logic [63:0] client_tx_data,
    input  wire logic [7:0]  client_tx_ctrl,
    output logic [63:0]      tx_data,
    output logic [7:0]       tx_ctrl,
    output logic             local_fault_status,
    output logic             remote_fault_status,
    output logic             irq
);
    fault_status_if st ();

    logic [3:0]  cfg_q;
    logic [3:0]  int_status_q;
    logic [3:0]  int_mask_q;
    logic        lf_prev_q;
    logic        rf_prev_q;
    logic [3:0]  events;
    logic        aw_held_q;
    logic        w_held_q;
    logic [15:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        do_write;
    logic        tx_has_term;
    logic        idle_pending_q;
    tx_action_e  action;

    // ************************************************************
    // receive fault detection
    // ************************************************************
    rx_fault_detect #(.HOLD_COLUMNS(HOLD_COLUMNS)) u_rx (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .rx_valid   (rx_valid),
        .rx_data    (rx_data),
        .rx_ctrl    (rx_ctrl),
        .rx_aligned (rx_aligned),
        .rx_hi_ber  (rx_hi_ber),
        .st         (st)
    );

    // ************************************************************
    // transmit decision
    // ************************************************************
    fault_decide u_dec (
        .cfg (cfg_q),
        .st  (st)
    );
    assign action = st.action;

    // ************************************************************
    // register bus
    // ************************************************************
    function automatic logic [31:0] read_word(input logic [15:0] addr, input logic [3:0] cfg,
                                              input logic [3:0] sts, input logic [3:0] msk,
                                              input logic lf, input logic rf);
        unique case (addr[15:2])
            LINK_FAULT_CONFIG_IDX: read_word = {28'h0000000, cfg};
            INT_STATUS_IDX:        read_word = {28'h0000000, sts};
            INT_MASK_IDX:          read_word = {28'h0000000, msk};
            LINK_STATUS_IDX:       read_word = {30'h00000000, rf, lf};
            default:               read_word = 32'h00000000;
        endcase
    endfunction : read_word

    function automatic logic is_mapped(input logic [15:0] addr);
        is_mapped = addr[15:2] == LINK_FAULT_CONFIG_IDX || addr[15:2] == INT_STATUS_IDX ||
                    addr[15:2] == INT_MASK_IDX || addr[15:2] == LINK_STATUS_IDX;
    endfunction : is_mapped

    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            s_axi_awready <= 1'b0;
            aw_addr_q     <= 16'h0000;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q     <= 1'b0;
            s_axi_wready <= 1'b0;
            w_data_q     <= 32'h00000000;
            w_strb_q     <= 4'h0;
        end else begin
            s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q      <= LINK_FAULT_CONFIG_RST;
            int_mask_q <= INT_MASK_RST;
        end else if (do_write && w_strb_q[0]) begin
            if (aw_addr_q[15:2] == LINK_FAULT_CONFIG_IDX) cfg_q <= w_data_q[3:0];
            if (aw_addr_q[15:2] == INT_MASK_IDX)          int_mask_q <= w_data_q[3:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= read_word(s_axi_araddr, cfg_q, int_status_q, int_mask_q,
                                          st.local_fault_condition, st.remote_fault_condition);
                s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    assign events = {rf_prev_q && !st.remote_fault_condition, !rf_prev_q && st.remote_fault_condition,
                     lf_prev_q && !st.local_fault_condition, !lf_prev_q && st.local_fault_condition};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lf_prev_q    <= 1'b0;
            rf_prev_q    <= 1'b0;
            int_status_q <= 4'h0;
            irq          <= 1'b0;
        end else begin
            lf_prev_q <= st.local_fault_condition;
            rf_prev_q <= st.remote_fault_condition;
            // new events win over a write-one clear in the same cycle
            if (do_write && w_strb_q[0] && aw_addr_q[15:2] == INT_STATUS_IDX)
                int_status_q <= (int_status_q & ~w_data_q[3:0]) | events;
            else
                int_status_q <= int_status_q | events;
            irq <= |(int_status_q & int_mask_q);
        end
    end

    // ************************************************************
    // status outputs and transmit column mux
    // ************************************************************
    // registered live status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            local_fault_status  <= 1'b0;
            remote_fault_status <= 1'b0;
        end else begin
            local_fault_status  <= st.local_fault_condition;
            remote_fault_status <= st.remote_fault_condition;
        end
    end

    assign tx_has_term = |(client_tx_ctrl & {client_tx_data[63:56] == CH_TERM, client_tx_data[55:48] == CH_TERM,
                                             client_tx_data[47:40] == CH_TERM, client_tx_data[39:32] == CH_TERM,
                                             client_tx_data[31:24] == CH_TERM, client_tx_data[23:16] == CH_TERM,
                                             client_tx_data[15:8] == CH_TERM, client_tx_data[7:0] == CH_TERM});

    // in TX_DATA_RF an all-control idle column may be replaced by a remote fault ordered set; data columns never are
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_data        <= {8{CH_IDLE}};
            tx_ctrl        <= 8'hff;
            idle_pending_q <= 1'b0;
        end else begin
            unique case (action)
                TX_PASS: begin
                    tx_data        <= client_tx_data;
                    tx_ctrl        <= client_tx_ctrl;
                    idle_pending_q <= 1'b0;
                end
                TX_IDLE: begin
                    tx_data        <= {8{CH_IDLE}};
                    tx_ctrl        <= 8'hff;
                    idle_pending_q <= 1'b0;
                end
                TX_RF: begin
                    tx_data        <= {SEQ_REMOTE, 16'h0000, CH_SEQ, SEQ_REMOTE, 16'h0000, CH_SEQ};
                    tx_ctrl        <= 8'h11;
                    idle_pending_q <= 1'b0;
                end
                TX_DATA_RF: begin
                    if (client_tx_ctrl == 8'hff && !idle_pending_q) begin
                        tx_data <= {SEQ_REMOTE, 16'h0000, CH_SEQ, SEQ_REMOTE, 16'h0000, CH_SEQ};
                        tx_ctrl <= 8'h11;
                    end else begin
                        tx_data <= client_tx_data;
                        tx_ctrl <= client_tx_ctrl;
                    end
                    idle_pending_q <= tx_has_term;
                end
            endcase
        end
    end
endmodule : link_fault_signaling

//--- hdl/rx_fault_detect.sv
// receive side fault detector: watches 64-bit xgmii columns for sequence ordered sets
// assumes data arrive synchronous to aclk with one 8-bit control mask per word
`timescale 1ns/1ps
module rx_fault_detect
    import lfs_pkg::*;
#(
    parameter int HOLD_COLUMNS = 128
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        rx_valid,
    input  wire logic [63:0] rx_data,
    input  wire logic [7:0]  rx_ctrl,
    input  wire logic        rx_aligned,
    input  wire logic        rx_hi_ber,
    fault_status_if.rx       st
);
    if (HOLD_COLUMNS < 2 || HOLD_COLUMNS > 65535) begin : g_hold_check
        $error("HOLD_COLUMNS out of range");
    end

    logic        seq_lane0;
    logic        is_lf;
    logic        is_rf;
    logic [15:0] quiet_q;
    logic        lf_q;
    logic        rf_q;

    assign seq_lane0 = rx_ctrl[0] && rx_data[7:0] == CH_SEQ;
    assign is_lf     = seq_lane0 && rx_data[31:24] == SEQ_LOCAL;
    assign is_rf     = seq_lane0 && rx_data[31:24] == SEQ_REMOTE;

    always_ff @(posedge aclk) begin
        if (!aresetn || !rx_aligned || rx_hi_ber) begin
            lf_q    <= 1'b0;
            rf_q    <= 1'b0;
            quiet_q <= 16'h0000;
        end else if (rx_valid) begin
            if (is_lf || is_rf) begin
                lf_q    <= is_lf;
                rf_q    <= is_rf;
                quiet_q <= 16'h0000;
            end else if (quiet_q == 16'(HOLD_COLUMNS - 1)) begin
                // status falls once no sequence has been seen for a while
                lf_q <= 1'b0;
                rf_q <= 1'b0;
            end else begin
                quiet_q <= quiet_q + 16'h0001;
            end
        end
    end

    assign st.local_fault_condition  = lf_q;
    assign st.remote_fault_condition = rf_q;
endmodule : rx_fault_detect

//--- test/lfs_checker_sva.sv
// checker for the link fault signaling top: bus answers, fault status, transmit columns
// assumes one clock aclk and the synchronous active-low reset aresetn
`timescale 1ns/1ps
module lfs_checker
    import lfs_pkg::*;
#(
    parameter int HOLD_COLUMNS = 128
) (
    input logic        aclk,
    input logic        aresetn,
    input logic [15:0] s_axi_awaddr,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0]  s_axi_wstrb,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        rx_valid,
    input logic [63:0] rx_data,
    input logic [7:0]  rx_ctrl,
    input logic        rx_aligned,
    input logic        rx_hi_ber,
    input logic [63:0] tx_data,
    input logic [7:0]  tx_ctrl,
    input logic        local_fault_status,
    input logic        remote_fault_status
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************
    // shadow of config
    // ****************
    // only simultaneous address and data handshakes are tracked, as the bench issues them
    logic [3:0] cfg_q;
    logic       seq_col;
    logic       tx_rf;
    assign seq_col = rx_valid && rx_aligned && !rx_hi_ber && rx_ctrl[0] && rx_data[7:0] == CH_SEQ;
    assign tx_rf   = tx_ctrl == 8'h11 && tx_data[7:0] == CH_SEQ && tx_data[31:24] == SEQ_REMOTE;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
                     && s_axi_awaddr == 16'(LINK_FAULT_CONFIG_ADDR)) begin
            cfg_q <= s_axi_wdata[3:0];
        end
    end
    // **********
    // assertions
    // **********
    force_rf_a: assert property ((cfg_q[0] && cfg_q[3]) [*4] |-> tx_rf)
        else $error("forced mode sent a column other than remote fault");
    off_no_rf_a: assert property ((!cfg_q[0]) [*4] |-> !tx_rf)
        else $error("disabled signaling sent remote fault");
    lf_set_a: assert property (seq_col && rx_data[31:24] == SEQ_LOCAL |-> ##2 local_fault_status)
        else $error("local fault status missed a local fault set");
    rf_set_a: assert property (seq_col && rx_data[31:24] == SEQ_REMOTE |-> ##2 remote_fault_status)
        else $error("remote fault status missed a remote fault set");
    blind_clear_a: assert property ((!rx_aligned || rx_hi_ber) [*2] |-> ##1
        !local_fault_status && !remote_fault_status)
        else $error("fault status held while receiver unusable");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before it was taken");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    lf_cov: cover property ($rose(local_fault_status));
    force_cov: cover property (cfg_q[3] && tx_rf);
    slverr_cov: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : lfs_checker

bind link_fault_signaling lfs_checker #(.HOLD_COLUMNS(HOLD_COLUMNS)) chk_u (.*);

//--- test/link_partner.sv
// model of the remote link partner: receive columns with or without fault ordered sets
// assumes the bench picks the fault kind; columns change just after each aclk edge
`timescale 1ns/1ps
module link_partner
    import lfs_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic [1:0] fault,
    output logic            rx_valid,
    output logic [63:0]     rx_data,
    output logic [7:0]      rx_ctrl
);
    initial begin
        rx_valid = 1'b0;
        rx_data  = 64'h0707070707070707;
        rx_ctrl  = 8'hff;
    end
    // a set in every column keeps the far status alive; a quiet link sends idles
    always @(posedge aclk) begin
        rx_valid <= 1'b1;
        rx_data  <= 64'h0707070707070707;
        rx_ctrl  <= 8'hff;
        if (fault != 2'h0) begin
            rx_data <= {32'h07070707, (fault == 2'h1) ? SEQ_LOCAL : SEQ_REMOTE, 16'h0000, CH_SEQ};
            rx_ctrl <= 8'hf1;
        end
    end
endmodule : link_partner

//--- test/tb.sv
// self-checking bench for the link fault signaling block
// assumes the checker binds itself and the partner model drives the receive side
`timescale 1ns/1ps
module tb;
    import lfs_pkg::*;
    // *******
    // signals
    // *******
    localparam logic [15:0] A_CFG = 16'(LINK_FAULT_CONFIG_ADDR);
    localparam logic [15:0] A_STS = 16'(INT_STATUS_ADDR);
    localparam logic [15:0] A_MSK = 16'(INT_MASK_ADDR);
    localparam logic [15:0] A_LNK = 16'(LINK_STATUS_ADDR);
    localparam logic [63:0] IDLE = 64'h0707070707070707;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, rx_aligned = 1'b1, rx_hi_ber = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, lf_st, rf_st, rx_valid;
    logic [15:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = '0;
    logic [1:0]  bresp, rresp, fault = 2'h0;
    logic [63:0] rx_data, tx_data, ctx_data = IDLE;
    logic [7:0]  rx_ctrl, tx_ctrl, ctx_ctrl = 8'hff;
    logic [33:0] rd_q[$];
    logic [1:0]  wr_q[$];
    logic [3:0]  cfgs[7] = '{4'h0, 4'h8, 4'h9, 4'hb, 4'h7, 4'h3, 4'h1};
    int          bad_count = 0, total_checks = 0, cycles = 0, seed = 57907;

    always #5 aclk = ~aclk;

    link_partner lp_u (.aclk(aclk), .fault(fault), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ctrl(rx_ctrl));
    link_fault_signaling #(.HOLD_COLUMNS(4)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ctrl(rx_ctrl),
        .rx_aligned(rx_aligned), .rx_hi_ber(rx_hi_ber), .client_tx_data(ctx_data), .client_tx_ctrl(ctx_ctrl),
        .tx_data(tx_data), .tx_ctrl(tx_ctrl), .local_fault_status(lf_st), .remote_fault_status(rf_st), .irq(irq));

    // *********
    // bus tasks
    // *********
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_cyc

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
        bit aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        wr_q.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
        rd_q.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    // the watcher takes the oldest note whenever an answer is taken
    always @(posedge aclk) begin
        if (rvalid && rready) check("rd_word", 64'({rresp, rdata}), 64'(rd_q.pop_front()));
        if (bvalid && bready) check("wr_resp", 64'(bresp), 64'(wr_q.pop_front()));
    end

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            complete_run();
        end
    end

    // *********
    // scenarios
    // *********
    // 0 pass, 1 idle, 2 remote fault, 3 data with remote fault in the gaps
    function automatic int act(input logic [3:0] c, input logic [1:0] f);
        if (!c[0]) return 0;
        if (c[3]) return 2;
        if (c[1]) return (!c[2] && f == 2'h1) ? 3 : 0;
        return (f == 2'h1) ? 2 : (f == 2'h2) ? 1 : 0;
    endfunction : act

    // data, a terminate in lane 4, then idles; one cycle of latency to the output
    task automatic run_cols(input int a);
        logic [63:0] nd, pd;
        logic [7:0]  nc, pc;
        bit          aft, rf;
        pd = ctx_data;
        pc = ctx_ctrl;
        aft = 1'b0;
        for (int i = 0; i < 8; i++) begin
            nd = (i < 4) ? {$random(seed), $random(seed)} : IDLE;
            nc = (i < 3) ? 8'h00 : 8'hff;
            if (i == 3) begin
                nd[63:32] = 32'h070707fd;
                nc = 8'hf0;
            end
            @(posedge aclk);
            ctx_data <= nd;
            ctx_ctrl <= nc;
            #1;
            rf = a == 2 || (a == 3 && pc == 8'hff && !aft);
            if (rf) check("tx_rf", 64'({tx_ctrl, tx_data[39:0]}), 64'h119c0200009c);
            else begin
                check("tx_data", tx_data, (a == 1) ? IDLE : pd);
                check("tx_ctrl", 64'(tx_ctrl), (a == 1) ? 64'hff : 64'(pc));
            end
            aft = pc == 8'hf0;
            pd = nd;
            pc = nc;
        end
        @(posedge aclk);
    endtask : run_cols

    initial begin
        wait_cyc(10);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(A_CFG, 32'h0, RESP_OKAY);
        rd(A_MSK, 32'h0, RESP_OKAY);
        rd(A_STS, 32'h0, RESP_OKAY);
        rd(A_LNK, 32'h0, RESP_OKAY);
        wr(A_CFG, 32'hfffffff5, RESP_OKAY);
        rd(A_CFG, 32'h5, RESP_OKAY);
        wr(16'h1030, 32'hffffffff, RESP_SLVERR);
        rd(16'h1030, 32'h0, RESP_SLVERR);
        $display("register test done");
        foreach (cfgs[j]) begin
            wr(A_CFG, {28'h0, cfgs[j]}, RESP_OKAY);
            for (int f = 0; f < 3; f++) begin
                fault <= 2'(f);
                wait_cyc(12);
                check("lf_status", 64'(lf_st), 64'(f == 1));
                check("rf_status", 64'(rf_st), 64'(f == 2));
                run_cols(act(cfgs[j], 2'(f)));
            end
        end
        $display("mode test done");
        fault <= 2'h1;
        wait_cyc(12);
        for (int k = 0; k < 2; k++) begin
            if (k == 0) rx_aligned <= 1'b0;
            else rx_hi_ber <= 1'b1;
            wait_cyc(6);
            check("lf_blind", 64'(lf_st), 64'h0);
            rx_aligned <= 1'b1;
            rx_hi_ber <= 1'b0;
            wait_cyc(6);
            check("lf_back", 64'(lf_st), 64'h1);
        end
        $display("blind receiver test done");
        fault <= 2'h0;
        wait_cyc(12);
        wr(A_STS, 32'hf, RESP_OKAY);
        rd(A_STS, 32'h0, RESP_OKAY);
        fault <= 2'h1;
        wait_cyc(10);
        check("irq_masked", 64'(irq), 64'h0);
        rd(A_STS, 32'h1, RESP_OKAY);
        rd(A_LNK, 32'h1, RESP_OKAY);
        wr(A_MSK, 32'h1, RESP_OKAY);
        wait_cyc(2);
        check("irq_on", 64'(irq), 64'h1);
        wr(A_STS, 32'h1, RESP_OKAY);
        wait_cyc(2);
        check("irq_off", 64'(irq), 64'h0);
        fault <= 2'h0;
        wait_cyc(12);
        rd(A_STS, 32'h2, RESP_OKAY);
        check("irq_fell", 64'(irq), 64'h0);
        $display("interrupt test done");
        complete_run();
    end
endmodule : tb
